// ==== design/ost_pkg.sv ====
// Package of the oscillation stabilization timer: select codes, status
// steps and power-on delay counts.
// Assumes a 250 MHz system clock; status counts in oscillator cycles.
package ost_pkg;

  // ********************************************************************
  // Widths and select codes
  // ********************************************************************
  localparam int unsigned SEL_W    = 3;
  localparam int unsigned STAT_W   = 5;
  localparam int unsigned CNT_W    = 18;
  localparam int unsigned NUM_STEP = 5;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h5;

  // Oscillator cycle count for each step (2^11 .. 2^18-1 cycles).
  localparam logic [CNT_W-1:0] STEP_CNT_0 = 18'h00800;
  localparam logic [CNT_W-1:0] STEP_CNT_1 = 18'h02000;
  localparam logic [CNT_W-1:0] STEP_CNT_2 = 18'h08000;
  localparam logic [CNT_W-1:0] STEP_CNT_3 = 18'h10000;
  localparam logic [CNT_W-1:0] STEP_CNT_4 = 18'h3ffff;

  // ********************************************************************
  // Power-on delay timing
  // ********************************************************************
  localparam real CLK_MHZ      = 250.0;
  localparam real POR_MIN_MS   = 1.93;
  localparam real POR_MAX_MS   = 5.39;
  // Least time rounds up, longest rounds down.
  localparam int  POR_MIN_CYC  = int'($ceil(POR_MIN_MS * CLK_MHZ * 1000.0));
  localparam int  POR_MAX_CYC  = int'($floor(POR_MAX_MS * CLK_MHZ * 1000.0));
  localparam int unsigned POR_W = 21;

  // Sequencer states.
  typedef enum logic [1:0] {
    OST_IDLE,
    OST_COUNT,
    OST_DONE
  } ost_state_t;

endpackage : ost_pkg

// ==== design/ost_por_delay.sv ====
// Power-on stabilization delay: holds reset processing for a fixed count
// after the supply detect level is crossed.
// Assumes supply_ok is already synchronised to sys_clk.
`timescale 1ns/10ps
module ost_por_delay #(
  parameter int unsigned DELAY_CYC = ost_pkg::POR_MIN_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Supply detect and release
  input  wire logic supply_ok,
  output logic      por_done
);

  logic [ost_pkg::POR_W-1:0] cnt;
  logic [ost_pkg::POR_W-1:0] next_cnt;
  logic                      next_done;

  // Counts while supply is good; drops back if the supply dips.
  always_comb begin
    next_cnt  = cnt;
    next_done = por_done;
    if (!supply_ok) begin
      next_cnt  = '0;
      next_done = 1'b0;
    end else if (!por_done) begin
      if (cnt == ost_pkg::POR_W'(DELAY_CYC - 1)) begin
        next_done = 1'b1;
      end
      next_cnt = cnt + ost_pkg::POR_W'(1);
    end
  end

  // Registers the delay state.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= '0;
      por_done <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      por_done <= next_done;
    end
  end

  // Release only follows a good supply.
  a_por_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(por_done) |-> $past(supply_ok))
    else $error("Power-on release without good supply.");

  // Release never comes earlier than the programmed count.
  a_por_count: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(por_done) |-> (cnt == ost_pkg::POR_W'(DELAY_CYC)))
    else $error("Power-on release before the full count.");

endmodule : ost_por_delay

// ==== design/ost_timer.sv ====
// Oscillation stabilization timer: counts oscillator cycles after start
// or standby release, reports step status, and gates the clock.
// Assumes the oscillator clock edge arrives as an async level pin.
//
// Operation
// - Counter runs from oscillator start to the selected wait, then stops.
// - After standby release status only advances up to the selected step.
// - Counting starts only once oscillation has actually started.
// - External clock input needs no wait; clock is released at once.
// - Power-on inserts 1.93 to 5.39 ms delay after supply detect.
// - Fast supply rise still gets automatic delay before reset processing.
`timescale 1ns/10ps
module ost_timer (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Power supply detect (pin)
  input  wire logic                        supply_ok_pin,
  output logic                             reset_release,
  // Oscillator side (pins)
  input  wire logic                        main_crystal_osc,
  input  wire logic                        osc_started_pin,
  input  wire logic                        ext_main_clock_in,
  // Control from the clock generator
  input  wire logic                        osc_enable,
  input  wire logic                        standby,
  input  wire logic [ost_pkg::SEL_W-1:0]   stab_time_select,
  // Status and clock gate
  output logic [ost_pkg::STAT_W-1:0]       stab_count_status,
  output logic                             clock_ready
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  logic [1:0] sync_osc;
  logic [1:0] sync_start;
  logic [1:0] sync_supply;
  logic       osc_prev;

  // Two flops on the oscillator, start and supply pins before any logic reads them; ext_main_clock_in is read directly.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_osc    <= 2'h0;
      sync_start  <= 2'h0;
      sync_supply <= 2'h0;
      osc_prev    <= 1'b0;
    end else begin
      sync_osc    <= {sync_osc[0], main_crystal_osc};
      sync_start  <= {sync_start[0], osc_started_pin};
      sync_supply <= {sync_supply[0], supply_ok_pin};
      osc_prev    <= sync_osc[1];
    end
  end

  logic osc_tick;
  assign osc_tick = sync_osc[1] & ~osc_prev;

  // ********************************************************************
  // Power-on delay
  // ********************************************************************
  ost_por_delay u_por (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .supply_ok (sync_supply[1]),
    .por_done  (reset_release)
  );

  // ********************************************************************
  // Step decode
  // ********************************************************************
  // Cycle count that completes a given step.
  function automatic logic [ost_pkg::CNT_W-1:0] step_cnt(
    input logic [ost_pkg::SEL_W-1:0] idx
  );
    case (idx)
      3'h0:    step_cnt = ost_pkg::STEP_CNT_0;
      3'h1:    step_cnt = ost_pkg::STEP_CNT_1;
      3'h2:    step_cnt = ost_pkg::STEP_CNT_2;
      3'h3:    step_cnt = ost_pkg::STEP_CNT_3;
      default: step_cnt = ost_pkg::STEP_CNT_4;
    endcase
  endfunction : step_cnt

  logic [ost_pkg::SEL_W-1:0] sel_step;
  assign sel_step = (stab_time_select > 3'h4) ? 3'h4 : stab_time_select;

  // ********************************************************************
  // Wait sequencer
  // ********************************************************************
  ost_pkg::ost_state_t          state;
  ost_pkg::ost_state_t          next_state;
  logic [ost_pkg::CNT_W-1:0]    cnt;
  logic [ost_pkg::CNT_W-1:0]    next_cnt;
  logic [ost_pkg::STAT_W-1:0]   next_status;
  logic                         next_ready;
  logic                         standby_prev;
  logic                         wait_start;

  assign wait_start = osc_enable & ~standby & (standby_prev | ~clock_ready)
                      & (state == ost_pkg::OST_IDLE);

  // Counts oscillator edges and sets status steps on the way.
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_status = stab_count_status;
    next_ready  = clock_ready;
    case (state)
      ost_pkg::OST_IDLE: begin
        if (standby || !osc_enable) begin
          next_status = '0;
          next_ready  = 1'b0;
          next_cnt    = '0;
        end else if (ext_main_clock_in) begin
          next_ready = 1'b1;
          next_state = ost_pkg::OST_DONE;
        end else if (wait_start) begin
          next_status = '0;
          next_cnt    = '0;
          next_state  = ost_pkg::OST_COUNT;
        end
      end
      ost_pkg::OST_COUNT: begin
        if (standby || !osc_enable) begin
          next_state  = ost_pkg::OST_IDLE;
          next_status = '0;
          next_ready  = 1'b0;
        end else if (sync_start[1] && osc_tick) begin
          next_cnt = cnt + ost_pkg::CNT_W'(1);
          for (int i = 0; i < ost_pkg::NUM_STEP; i++) begin
            if (3'(i) <= sel_step && next_cnt >= step_cnt(3'(i))) begin
              next_status[ost_pkg::STAT_W-1-i] = 1'b1;
            end
          end
          if (next_cnt >= step_cnt(sel_step)) begin
            next_ready = 1'b1;
            next_state = ost_pkg::OST_DONE;
          end
        end
      end
      ost_pkg::OST_DONE: begin
        if (standby || !osc_enable) begin
          next_state  = ost_pkg::OST_IDLE;
          next_status = '0;
          next_ready  = 1'b0;
        end
      end
      default: next_state = ost_pkg::OST_IDLE;
    endcase
  end

  // Registers the sequencer state.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state             <= ost_pkg::OST_IDLE;
      cnt               <= '0;
      stab_count_status <= '0;
      clock_ready       <= 1'b0;
      standby_prev      <= 1'b0;
    end else begin
      state             <= next_state;
      cnt               <= next_cnt;
      stab_count_status <= next_status;
      clock_ready       <= next_ready;
      standby_prev      <= standby;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_cnt_stops: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (state == ost_pkg::OST_DONE)
    |=> ($stable(cnt) || state != ost_pkg::OST_DONE))
    else $error("Counter moved after wait end.");

  a_no_osc_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (state == ost_pkg::OST_COUNT && !sync_start[1]) |=> $stable(cnt))
    else $error("Counter moved before oscillation start.");

  a_status_cap: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (sel_step < 3'h4) |-> !stab_count_status[0])
    else $error("Status beyond selected step set.");

  a_standby_clr: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    standby |=> (stab_count_status == '0) && !clock_ready)
    else $error("Status not cleared on standby.");

  a_ext_clk: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (state == ost_pkg::OST_IDLE && osc_enable && !standby
     && ext_main_clock_in) |=> clock_ready)
    else $error("External clock not released at once.");

endmodule : ost_timer

// ==== testbench/ost_timer_test.sv ====
// Self-checking bench for the stabilization timer and power-on delay.
// Assumes the design package is compiled first; inputs move on falling edges.
`timescale 1ns/10ps
module ost_timer_test;
  // ******************************************************************
  // Signals and instances
  // ******************************************************************
  logic                       sys_clk, rst_b, supply_ok_pin, reset_release;
  logic                       main_crystal_osc, osc_started_pin;
  logic                       ext_main_clock_in, osc_enable, standby;
  logic [ost_pkg::SEL_W-1:0]  stab_time_select;
  logic [ost_pkg::STAT_W-1:0] stab_count_status;
  logic                       clock_ready;
  int                         fails, n_checks;

  // Timer under test, all inputs driven by the bench.
  ost_timer dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .supply_ok_pin(supply_ok_pin), .reset_release(reset_release),
    .main_crystal_osc(main_crystal_osc), .osc_started_pin(osc_started_pin),
    .ext_main_clock_in(ext_main_clock_in), .osc_enable(osc_enable),
    .standby(standby), .stab_time_select(stab_time_select),
    .stab_count_status(stab_count_status), .clock_ready(clock_ready));

  // Free-running 250 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %b, seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_stat(input logic [ost_pkg::STAT_W-1:0] exp);
    n_checks++;
    if (stab_count_status !== exp) begin
      fails++;
      $display("unexpected status: expected %h, seen %h", exp,
               stab_count_status);
    end
  endtask : chk_stat

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // Each oscillator period spans four system cycles to clear the synchroniser.
  task automatic ticks(input int n);
    repeat (n) begin
      main_crystal_osc = 1'b1;
      cyc(2);
      main_crystal_osc = 1'b0;
      cyc(2);
    end
  endtask : ticks

  // Bounded wait for the clock release; giving up ends the run.
  task automatic wait_ready(input int lim);
    int i;
    i = 0;
    while (clock_ready !== 1'b1 && i < lim) begin
      cyc(1);
      i++;
    end
    chk_bit("clock_ready", 1'b1, clock_ready);
    if (clock_ready !== 1'b1) summarize();
  endtask : wait_ready

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  // Ticks before oscillation starts must not count toward the wait.
  task automatic t_not_started();
    osc_enable = 1'b1;
    stab_time_select = 3'h0;
    ticks(2100);
    cyc(8);
    chk_bit("clock_ready", 1'b0, clock_ready);
    chk_stat(5'h00);
  endtask : t_not_started

  // Shortest step: release exactly on the last tick, then counting stops.
  task automatic t_step0();
    osc_started_pin = 1'b1;
    cyc(4);
    ticks(2047);
    cyc(8);
    chk_bit("clock_ready", 1'b0, clock_ready);
    ticks(1);
    wait_ready(8);
    ticks(100);
    cyc(8);
    chk_stat(5'h10);
    chk_bit("clock_ready", 1'b1, clock_ready);
  endtask : t_step0

  // Standby clears all flags and the clock release.
  task automatic t_standby();
    standby = 1'b1;
    cyc(6);
    chk_stat(5'h00);
    chk_bit("clock_ready", 1'b0, clock_ready);
  endtask : t_standby

  // Second step after standby exit: flags build up cumulatively.
  task automatic t_step1();
    stab_time_select = 3'h1;
    cyc(2);
    standby = 1'b0;
    ticks(2048);
    cyc(8);
    chk_stat(5'h10);
    chk_bit("clock_ready", 1'b0, clock_ready);
    ticks(6144);
    wait_ready(8);
    chk_stat(5'h18);
  endtask : t_step1

  // External clock input releases at once with no ticks at all.
  task automatic t_ext();
    standby = 1'b1;
    cyc(4);
    ext_main_clock_in = 1'b1;
    osc_started_pin = 1'b0;
    standby = 1'b0;
    wait_ready(8);
  endtask : t_ext

  // Supply detect starts the power-on count through the top. The full
  // delay outlasts the run, so the release must stay low, also after a dip.
  task automatic t_por();
    chk_bit("reset_release", 1'b0, reset_release);
    supply_ok_pin = 1'b1;
    cyc(200);
    chk_bit("reset_release", 1'b0, reset_release);
    supply_ok_pin = 1'b0;
    cyc(4);
    supply_ok_pin = 1'b1;
    cyc(8);
    chk_bit("reset_release", 1'b0, reset_release);
  endtask : t_por

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    fails = 0;
    n_checks = 0;
    rst_b = 1'b0;
    supply_ok_pin = 1'b0;
    main_crystal_osc = 1'b0;
    osc_started_pin = 1'b0;
    ext_main_clock_in = 1'b0;
    osc_enable = 1'b0;
    standby = 1'b0;
    stab_time_select = ost_pkg::SEL_RESET;
    cyc(2);
    rst_b = 1'b1;
    cyc(2);
    chk_stat(5'h00);
    chk_bit("clock_ready", 1'b0, clock_ready);
    t_por();
    t_not_started();
    t_step0();
    t_standby();
    t_step1();
    t_ext();
    chk_bit("reset_release", 1'b0, reset_release);
    summarize();
  end
endmodule : ost_timer_test
